// ===== tcal_pkg.sv
// Package for the termination calibration sequencer.
// Assumes a 125 MHz system clock and a 32-bit APB slave port.
package tcal_pkg;
  localparam int unsigned NUM_BLOCKS = 10;
  localparam int unsigned NUM_BANKS = 16;
  localparam int unsigned SYS_CLK_MHZ = 125;
  localparam int unsigned USER_CLK_MAX_MHZ = 20;
  // Half period of the calibration clock in system cycles, rounded up.
  localparam int unsigned CAL_HALF_DIV =
    (SYS_CLK_MHZ + 2 * USER_CLK_MAX_MHZ - 1) / (2 * USER_CLK_MAX_MHZ);
  localparam int unsigned FULL_CAL_CYCLES = 1000;
  localparam int unsigned SERIES_CAL_CYCLES = 240;
  localparam int unsigned SHIFT_CYCLES = 28;
  localparam int unsigned CODE_BITS = 28;
  localparam int unsigned LOAD_TIME_NS = 25;
  localparam int unsigned CAL_CLK_PERIOD_NS =
    2 * CAL_HALF_DIV * 1000 / SYS_CLK_MHZ;
  // Minimum load pulse length in calibration clock cycles, rounded up.
  localparam int unsigned LOAD_CYCLES =
    (LOAD_TIME_NS + CAL_CLK_PERIOD_NS - 1) / CAL_CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 10;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_BANKS = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_SERIES_ONLY = 1;
  localparam int unsigned CTRL_CAL = 2;
  localparam int unsigned CTRL_BLK_LSB = 4;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_DONE = 1;
  localparam int unsigned STAT_STATE_LSB = 4;
  localparam int unsigned STATE_W = 8;
  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_MODE = 8'b0000_0010,
    ST_CLEAR = 8'b0000_0100,
    ST_CAL = 8'b0000_1000,
    ST_GAP = 8'b0001_0000,
    ST_SHIFT = 8'b0010_0000,
    ST_LOAD = 8'b0100_0000,
    ST_DONE = 8'b1000_0000
  } seq_state_type;
endpackage : tcal_pkg

// ===== tcal_clk_div.sv
// Calibration clock divider producing the outgoing clock and a rise enable.
// Assumes a single system clock; all sequencing runs on the rise pulse.
module tcal_clk_div (
  input wire logic mclk_in, // System clock.
  input wire logic rst_in, // Synchronous reset, active high.
  output logic cal_clk_out, // Divided clock, registered.
  output logic rise_out // One-cycle pulse with each rising edge.
);
  import tcal_pkg::*;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic clk_nxt;
  logic rise_nxt;
  always_comb begin
    cnt_nxt = cnt_r + 8'h01;
    clk_nxt = cal_clk_out;
    rise_nxt = 1'b0;
    if (cnt_r == 8'(CAL_HALF_DIV - 1)) begin
      cnt_nxt = 8'h00;
      clk_nxt = ~cal_clk_out;
      rise_nxt = ~cal_clk_out;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cnt_r <= 8'h00;
      cal_clk_out <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      cal_clk_out <= clk_nxt;
      rise_out <= rise_nxt;
    end
  end
endmodule : tcal_clk_div

// ===== tcal_sequencer.sv
// Controller that calibrates one termination block and loads its banks.
// Assumes APB from software and the device's calibration pins outside.
// Functional notes
// R01: Device calibrates itself at power up.
// R02: Mode select high calibrates, low shifts.
// R03: Enable bit starts calibration or serializer.
// R04: Calibration clock at most 20 MHz.
// R05: Controls change on calibration clock rise.
// R06: Mode select rises one cycle before enable.
// R07: Clear low one cycle before enable.
// R08: Full calibration holds enable 1000 cycles.
// R09: Mode select drops one cycle after enable.
// R10: Block shifts 28-bit series/parallel code.
// R11: At most one enable during transfer.
// R12: Wait one cycle before transfer enable.
// R13: Transfer enable held exactly 28 cycles.
// R14: One idle cycle between enable pulses.
// R15: Load one cycle after, at least 25 ns.
// R16: Banks convert code on parallel load.
// R17: Banks load together or separately.
// R18: No bank I/O traffic during load.
// R19: Mode select high while any calibrating.
// R20: Later clear leaves running calibration alone.
// R21: Series-only calibration holds enable 240 cycles.
// R22: Series-only still shifts 28 cycles.
// R23: Banks take codes from same-supply blocks.
// R24: Code in use changes only on load.
// R25: Reset leaves controls low, clear high.
module tcal_sequencer (
  input wire logic mclk_in, // System clock.
  input wire logic rst_in, // Synchronous reset.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  output logic cal_clk_out, // Calibration clock to the device.
  output logic cal_mode_select_out, // Calibrate high, shift low.
  output logic cal_clear_n_out, // Active-low clear.
  output logic [tcal_pkg::NUM_BLOCKS-1:0] block_enable_vector_out, // Enables.
  output logic [tcal_pkg::NUM_BANKS-1:0] bank_parallel_load_out, // Loads.
  output logic [tcal_pkg::NUM_BANKS-1:0] bank_io_hold_out // I/O quiet.
);
  import tcal_pkg::*;
  logic tick;
  seq_state_type state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [3:0] blk_r, blk_nxt;
  logic series_r, series_nxt;
  logic cal_r, cal_nxt;
  logic [NUM_BANKS-1:0] banks_r, banks_nxt;
  logic done_r, done_nxt;
  logic mode_nxt, clr_nxt;
  logic [NUM_BLOCKS-1:0] en_nxt;
  logic [NUM_BANKS-1:0] load_nxt;
  logic [31:0] rdata_nxt;
  logic wr_ok, start_wr;

  // The divider keeps every control change aligned to a clock rise.
  tcal_clk_div u_div ( // R04
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .cal_clk_out(cal_clk_out),
    .rise_out(tick)
  );

  assign wr_ok = psel && penable && pwrite;
  assign start_wr = wr_ok && (paddr == ADDR_CTRL) && pwdata[CTRL_START] &&
                    (state_r == ST_IDLE || state_r == ST_DONE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    blk_nxt = blk_r;
    series_nxt = series_r;
    cal_nxt = cal_r;
    banks_nxt = banks_r;
    done_nxt = done_r;
    mode_nxt = cal_mode_select_out;
    clr_nxt = cal_clear_n_out;
    en_nxt = block_enable_vector_out;
    load_nxt = bank_parallel_load_out;
    if (wr_ok && paddr == ADDR_BANKS && state_r != ST_LOAD) begin
      banks_nxt = pwdata[NUM_BANKS-1:0]; // R23
    end
    if (start_wr) begin
      blk_nxt = pwdata[CTRL_BLK_LSB +: 4];
      series_nxt = pwdata[CTRL_SERIES_ONLY];
      cal_nxt = pwdata[CTRL_CAL];
      done_nxt = 1'b0;
      state_nxt = pwdata[CTRL_CAL] ? ST_MODE : ST_GAP;
      cnt_nxt = '0;
    end else if (tick) begin // R05
      cnt_nxt = cnt_r + 1'b1;
      unique case (state_r)
        ST_IDLE, ST_DONE: begin
          cnt_nxt = '0;
        end
        ST_MODE: begin
          mode_nxt = 1'b1; // R06 R02
          state_nxt = ST_CLEAR;
          cnt_nxt = '0;
        end
        ST_CLEAR: begin
          clr_nxt = 1'b0; // R07 R20
          state_nxt = ST_CAL;
          cnt_nxt = '0;
        end
        ST_CAL: begin
          clr_nxt = 1'b1;
          en_nxt = '0;
          en_nxt[blk_r] = 1'b1; // R03
          if (cnt_r == CNT_W'(series_r ? SERIES_CAL_CYCLES
                                       : FULL_CAL_CYCLES)) begin
            en_nxt = '0; // R08 R21
            state_nxt = ST_GAP;
            cnt_nxt = '0;
          end
        end
        ST_GAP: begin
          // Mode select stays high until the enable has been low two cycles.
          en_nxt = '0;
          if (cnt_r == CNT_W'(0)) begin
            mode_nxt = cal_mode_select_out; // R19
          end else if (cnt_r == CNT_W'(1)) begin
            mode_nxt = 1'b0; // R09
          end else begin
            state_nxt = ST_SHIFT; // R12 R14
            cnt_nxt = '0;
          end
        end
        ST_SHIFT: begin
          en_nxt = '0;
          en_nxt[blk_r] = 1'b1; // R11 R10 R22
          if (cnt_r == CNT_W'(SHIFT_CYCLES)) begin
            en_nxt = '0; // R13
            state_nxt = ST_LOAD;
            cnt_nxt = '0;
          end
        end
        ST_LOAD: begin
          if (cnt_r == CNT_W'(0)) begin
            load_nxt = banks_r; // R15 R16 R17 R24
          end else if (cnt_r == CNT_W'(LOAD_CYCLES + 1)) begin
            load_nxt = '0;
            done_nxt = 1'b1;
            state_nxt = ST_DONE;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (paddr == ADDR_CTRL) begin
      rdata_nxt[CTRL_SERIES_ONLY] = series_r;
      rdata_nxt[CTRL_CAL] = cal_r;
      rdata_nxt[CTRL_BLK_LSB +: 4] = blk_r;
    end else if (paddr == ADDR_BANKS) begin
      rdata_nxt[NUM_BANKS-1:0] = banks_r;
    end else if (paddr == ADDR_STATUS) begin
      rdata_nxt[STAT_BUSY] = (state_r != ST_IDLE) && (state_r != ST_DONE);
      rdata_nxt[STAT_DONE] = done_r;
      rdata_nxt[STAT_STATE_LSB +: STATE_W] = state_r;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      blk_r <= 4'h0;
      series_r <= 1'b0;
      cal_r <= 1'b0;
      banks_r <= '0;
      done_r <= 1'b0;
      cal_mode_select_out <= 1'b0; // R25
      cal_clear_n_out <= 1'b1;
      block_enable_vector_out <= '0;
      bank_parallel_load_out <= '0;
      bank_io_hold_out <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      blk_r <= blk_nxt;
      series_r <= series_nxt;
      cal_r <= cal_nxt;
      banks_r <= banks_nxt;
      done_r <= done_nxt;
      cal_mode_select_out <= mode_nxt;
      cal_clear_n_out <= clr_nxt;
      block_enable_vector_out <= en_nxt;
      bank_parallel_load_out <= load_nxt;
      bank_io_hold_out <= load_nxt | bank_parallel_load_out; // R18
      prdata <= rdata_nxt;
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr != ADDR_CTRL) &&
                 (paddr != ADDR_BANKS) && (paddr != ADDR_STATUS);
    end
  end

  // Helper: calibration clock cycles with an enable high, counted on each rise.
  logic [CNT_W-1:0] en_len_r;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      en_len_r <= '0;
    end else if (tick) begin
      en_len_r <= (|block_enable_vector_out) ? en_len_r + 1'b1 : '0;
    end
  end

  property p_onehot_enable;
    @(posedge mclk_in) disable iff (rst_in)
      $onehot0(block_enable_vector_out);
  endproperty
  a_onehot_enable: assert property (p_onehot_enable) // R11
    else $error("more than one block enable high");

  property p_shift_len;
    @(posedge mclk_in) disable iff (rst_in)
      (tick && !cal_mode_select_out && |block_enable_vector_out &&
       en_nxt == '0) |-> en_len_r == CNT_W'(SHIFT_CYCLES - 1);
  endproperty
  a_shift_len: assert property (p_shift_len) // R13
    else $error("transfer enable not 28 cycles");

  property p_mode_before_enable;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(|block_enable_vector_out) && state_r == ST_CAL |->
        $past(cal_mode_select_out, CAL_HALF_DIV * 2);
  endproperty
  a_mode_before_enable: assert property (p_mode_before_enable) // R06
    else $error("mode select not high before enable");

  property p_clear_before_enable;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(|block_enable_vector_out) && state_r == ST_CAL |->
        !$past(cal_clear_n_out, CAL_HALF_DIV * 2);
  endproperty
  a_clear_before_enable: assert property (p_clear_before_enable) // R07
    else $error("clear not low before calibration enable");

  property p_mode_held;
    @(posedge mclk_in) disable iff (rst_in)
      (state_r == ST_CAL && |block_enable_vector_out) |->
        cal_mode_select_out;
  endproperty
  a_mode_held: assert property (p_mode_held) // R19
    else $error("mode select low during calibration");

  property p_load_after_shift;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(|bank_parallel_load_out) |-> !(|block_enable_vector_out) &&
        !cal_mode_select_out;
  endproperty
  a_load_after_shift: assert property (p_load_after_shift) // R15
    else $error("load raised during transfer");

  property p_io_hold;
    @(posedge mclk_in) disable iff (rst_in)
      (|bank_parallel_load_out) |=> (|bank_io_hold_out);
  endproperty
  a_io_hold: assert property (p_io_hold) // R18
    else $error("bank I/O not held during load");

  property p_reset_idle;
    @(posedge mclk_in) rst_in |=> cal_clear_n_out && !cal_mode_select_out &&
      block_enable_vector_out == '0 && bank_parallel_load_out == '0;
  endproperty
  a_reset_idle: assert property (p_reset_idle) // R25
    else $error("controls not idle after reset");

  c_cal: cover property (@(posedge mclk_in) state_r == ST_CAL ##1
    state_r == ST_GAP);
  c_shift: cover property (@(posedge mclk_in) state_r == ST_SHIFT ##1
    state_r == ST_LOAD);
  c_done: cover property (@(posedge mclk_in) $rose(done_r));
endmodule : tcal_sequencer

// ===== tcal_device_model.sv
// Behavioural model of the calibration blocks and the banks they feed.
// Assumes controls change only just after a calibration clock rise.
module tcal_device_model (
  input wire logic mclk_in, // System clock.
  input wire logic rst_in, // Synchronous reset.
  input wire logic cal_clk_in, // Calibration clock.
  input wire logic cal_mode_select_in, // Calibrate high, shift low.
  input wire logic cal_clear_n_in, // Active-low clear.
  input wire logic [tcal_pkg::NUM_BLOCKS-1:0] en_in, // Block enables.
  input wire logic [tcal_pkg::NUM_BANKS-1:0] load_in, // Bank loads.
  input wire logic [tcal_pkg::NUM_BANKS-1:0] hold_in // Bank I/O quiet.
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcal_pkg::*;
  // Every block starts out holding an all-zero code until a calibration run sets one.
  logic [27:0] code [NUM_BLOCKS] = '{default: 28'h000_0000};
  logic [NUM_BLOCKS+NUM_BANKS+1:0] ctl_fall =
    {2'b01, {(NUM_BLOCKS + NUM_BANKS){1'b0}}};
  real last_rise = 0.0;
  logic [27:0] bank_code [NUM_BANKS];
  logic [27:0] line_sr = '0;
  int cal_cnt [NUM_BLOCKS];
  logic [NUM_BLOCKS-1:0] en_r = '0;
  logic mode_r = 1'b0;
  logic clear_n_r = 1'b1;
  logic [NUM_BANKS-1:0] load_r;
  logic [NUM_BANKS-1:0] load_mask = '0;
  int run = 0, cal_len = 0, shift_len = 0, blk = 0, n_shift = 0;
  int n_err = 0, n_err_io = 0, load_ns = 0, load_run = 0;

  always @(posedge cal_clk_in) begin
    if ({cal_mode_select_in, cal_clear_n_in, en_in, load_in} != ctl_fall)
      n_err++;
    if (last_rise > 0.0 &&
        $realtime - last_rise < 1000.0 / USER_CLK_MAX_MHZ) n_err++;
    last_rise = $realtime;
    if (en_in != 0) run++;
    if (!$onehot0(en_in)) n_err++;
    if (en_in != 0 && en_r != 0 && en_in != en_r) n_err++;
    if (en_in != 0 && en_r == 0) begin
      blk = $clog2(en_in);
      if (cal_mode_select_in && !(mode_r && !clear_n_r)) n_err++;
      if (!cal_mode_select_in && mode_r) n_err++;
    end
    if (!cal_mode_select_in && mode_r && en_r != 0) n_err++;
    if (cal_mode_select_in) begin
      for (int b = 0; b < NUM_BLOCKS; b++) begin
        if (en_in[b]) cal_cnt[b]++;
        else if (!cal_clear_n_in) cal_cnt[b] = 0;
      end
    end else if (en_in[blk]) begin
      line_sr = {code[blk][0], line_sr[27:1]};
      code[blk] = {code[blk][0], code[blk][27:1]};
    end
    if (en_in == 0 && en_r != 0) begin
      if (mode_r) begin
        if (cal_cnt[blk] != run) n_err++;
        cal_len = run;
        code[blk] = {14'(blk + 1), 14'(run)};
      end else begin
        shift_len = run;
        n_shift++;
      end
      run = 0;
    end
    en_r = en_in;
    mode_r = cal_mode_select_in;
    clear_n_r = cal_clear_n_in;
  end

  // Controls seen at a fall must still stand at the next rise.
  always @(negedge cal_clk_in) begin
    if (!rst_in)
      ctl_fall = {cal_mode_select_in, cal_clear_n_in, en_in, load_in};
  end

  // Banks only take the line on a load edge, so shifting never disturbs them.
  always @(posedge mclk_in) begin
    if (rst_in) begin
      load_r <= '0;
      load_run <= 0;
    end else begin
      load_r <= load_in;
      if ((load_in & ~hold_in) != 0) n_err_io <= n_err_io + 1;
      for (int b = 0; b < NUM_BANKS; b++)
        if (load_in[b] && !load_r[b])
          bank_code[b] <= line_sr;
      if (load_in != 0) begin
        load_run <= load_run + 1;
        load_mask <= load_in;
      end else if (load_r != 0) begin
        load_ns <= load_run * 1000 / SYS_CLK_MHZ;
        load_run <= 0;
      end
    end
  end
endmodule : tcal_device_model

// ===== test_tcal_sequencer.sv
// Self-checking testbench for the termination calibration sequencer.
// Assumes the device model watches every calibration pin of the design.
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g); \
    end \
  end

module test_tcal_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import tcal_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, cal_clk, mode, clear_n;
  logic [NUM_BLOCKS-1:0] en;
  logic [NUM_BANKS-1:0] load, hold;
  int n_mismatch = 0, n_compared = 0, n_shift_exp = 0;

  always #4 mclk_in = ~mclk_in;

  tcal_sequencer i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_clk_out(cal_clk), .cal_mode_select_out(mode),
    .cal_clear_n_out(clear_n), .block_enable_vector_out(en),
    .bank_parallel_load_out(load), .bank_io_hold_out(hold));

  tcal_device_model i_model (.mclk_in(mclk_in), .rst_in(rst_in),
    .cal_clk_in(cal_clk), .cal_mode_select_in(mode),
    .cal_clear_n_in(clear_n), .en_in(en), .load_in(load), .hold_in(hold));

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_reset();
    logic [31:0] rd;
    logic er;
    `CHK("mode", 1'b0, mode);
    `CHK("clear_n", 1'b1, clear_n);
    `CHK("enables", 10'h000, en);
    `CHK("loads", 16'h0000, load);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000, rd, er);
    `CHK("status", 32'h0000_0010, rd);
    `CHK("status error", 1'b0, er);
    apb(1'b1, 12'h00C, 32'h0000_0001, rd, er);
    `CHK("unmapped error", 1'b1, er);
    $display("test reset done");
  endtask : t_reset

  // A second start is sent while busy; it must not add a sequence.
  task automatic t_run(input logic cal, input logic series, input int b,
      input logic [15:0] mask, input int len);
    logic [31:0] rd, ctrl;
    logic er;
    int n;
    ctrl = 32'(b) << CTRL_BLK_LSB;
    ctrl[CTRL_START] = 1'b1;
    ctrl[CTRL_SERIES_ONLY] = series;
    ctrl[CTRL_CAL] = cal;
    apb(1'b1, ADDR_BANKS, {16'h0000, mask}, rd, er);
    apb(1'b1, ADDR_CTRL, ctrl, rd, er);
    apb(1'b1, ADDR_CTRL, ctrl, rd, er);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000, rd, er);
    `CHK("busy", 1'b1, rd[STAT_BUSY]);
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0000_0000, rd, er);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 5000);
    if (n >= 5000) begin
      n_mismatch++;
      end_of_test();
    end
    n_shift_exp++;
    `CHK("done", 1'b1, rd[STAT_DONE]);
    apb(1'b0, ADDR_BANKS, 32'h0000_0000, rd, er);
    `CHK("banks", {16'h0000, mask}, rd);
    apb(1'b0, ADDR_CTRL, 32'h0000_0000, rd, er);
    `CHK("ctrl", {ctrl[31:1], 1'b0}, rd);
    if (cal) `CHK("cal length", len, i_model.cal_len);
    `CHK("shift length", 28, i_model.shift_len);
    `CHK("block", b, i_model.blk);
    `CHK("shifts", n_shift_exp, i_model.n_shift);
    `CHK("load mask", mask, i_model.load_mask);
    `CHK("load long", 1'b1, i_model.load_ns >= 25);
    `CHK("pins", 0, i_model.n_err);
    `CHK("io quiet", 0, i_model.n_err_io);
    for (int k = 0; k < NUM_BANKS; k++)
      if (mask[k]) `CHK("bank code", {14'(b + 1), 14'(len)},
        i_model.bank_code[k]);
  endtask : t_run

  task automatic t_full();
    t_run(1'b1, 1'b0, 9, 16'h0005, 1000);
    $display("test full calibration done");
  endtask : t_full

  task automatic t_series();
    t_run(1'b1, 1'b1, 0, 16'h8004, 240);
    `CHK("kept code", {14'd10, 14'd1000}, i_model.bank_code[0]);
    $display("test series calibration done");
  endtask : t_series

  task automatic t_shift_only();
    t_run(1'b0, 1'b0, 9, 16'h0002, 1000);
    $display("test shift only done");
  endtask : t_shift_only

  initial begin
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    t_reset();
    t_full();
    t_series();
    t_shift_only();
    end_of_test();
  end
endmodule : test_tcal_sequencer
